// ===== bench/lpmd_core_assertions.sv
// Purpose: Port checks of the low-power controller.
// Assumes: EPROM part; restart counted in bus ticks.
// Notes: A helper counter measures the restart length.
`timescale 1ns/1ps
`default_nettype none
module lpmd_core_assertions #(
    parameter STOP_DELAY = 4064
) (
    // Clock, reset, requests
    input wire logic mclk,
    input wire logic rst,
    input wire logic stop_exec,
    input wire logic wait_exec,
    input wire logic irq_ext,
    input wire logic irq_kbd,
    input wire logic irq_low_voltage_input,
    // Power control
    input wire logic bus_clk_en,
    input wire logic osc_run,
    input wire logic cpu_run,
    input wire logic core_timer_run,
    input wire logic timer16_run,
    input wire logic adc_run,
    input wire logic clear_imask
);
    logic [15:0] rs_cnt;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    // Holds 1 in stop, then counts restart cycles; wait leaves it at 0.
    always @(posedge mclk) begin
        if (rst || cpu_run)
            rs_cnt <= 16'h0000;
        else if (!osc_run)
            rs_cnt <= 16'h0001;
        else if (rs_cnt != 16'h0000)
            rs_cnt <= rs_cnt + 16'h0001;
    end
    sequence s_stopped;
        !osc_run && !cpu_run && clear_imask;
    endsequence
    sequence s_waiting;
        !cpu_run && core_timer_run && timer16_run && adc_run && clear_imask;
    endsequence
    property p_stop_in; stop_exec && cpu_run && osc_run |=> s_stopped; endproperty
    a_stop_in: assert property (p_stop_in) else $error("stop entry");
    property p_wait_in; wait_exec && !stop_exec && cpu_run && osc_run |=> s_waiting; endproperty
    a_wait_in: assert property (p_wait_in) else $error("wait entry");
    property p_frozen; !osc_run && !$past(osc_run) |-> !core_timer_run && !bus_clk_en; endproperty
    a_frozen: assert property (p_frozen) else $error("stop freeze");
    property p_stay; !osc_run && !irq_ext && !irq_kbd && !irq_low_voltage_input |=> !osc_run; endproperty
    a_stay: assert property (p_stay) else $error("stop exit");
    property p_wake; !osc_run && irq_ext |=> osc_run; endproperty
    a_wake: assert property (p_wake) else $error("stop wake");
    property p_rs_min; $rose(cpu_run) |-> rs_cnt == 0 || rs_cnt >= 2 * STOP_DELAY - 2; endproperty
    a_rs_min: assert property (p_rs_min) else $error("restart short");
    property p_rs_max; rs_cnt <= 2 * STOP_DELAY + 8; endproperty
    a_rs_max: assert property (p_rs_max) else $error("restart long");
    property p_wt_wake; osc_run && !cpu_run && rs_cnt == 0 && irq_ext |-> ##[1:3] cpu_run; endproperty
    a_wt_wake: assert property (p_wt_wake) else $error("wait wake");
endmodule
bind lpmd_core lpmd_core_assertions #(.STOP_DELAY(STOP_DELAY)) u_chk (
    .mclk(mclk), .rst(rst), .stop_exec(stop_exec), .wait_exec(wait_exec), .irq_ext(irq_ext),
    .irq_kbd(irq_kbd), .irq_low_voltage_input(irq_low_voltage_input), .bus_clk_en(bus_clk_en),
    .osc_run(osc_run), .cpu_run(cpu_run), .core_timer_run(core_timer_run),
    .timer16_run(timer16_run), .adc_run(adc_run), .clear_imask(clear_imask));
`default_nettype wire

// ===== bench/lpmd_core_tb.sv
// Purpose: Self-checking bench for the low-power and decode core.
// Assumes: EPROM part with a short restart delay.
// Notes: Expected values come from bench functions and literal constants only.
`timescale 1ns/1ps
`default_nettype none
module lpmd_core_tb;
    localparam int SD = 8;
    logic mclk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, cpu_wr = 1'b0, ims = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00, cpu_wdata = 8'h00;
    logic [1:0] cmd = 2'h0;
    logic [4:0] irq = 5'h00;
    logic [12:0] cpu_addr = 13'h0000;
    logic [12:0] cor [8] = '{13'h001F, 13'h0020, 13'h00BF, 13'h00C0, 13'h06FF, 13'h1F00,
        13'h1FDF, 13'h1FF0};
    wire logic [7:0] rdata;
    wire logic stop_exec, wait_exec, osc, run, ctr, t16r, adcr, clr, pgm;
    wire logic s_reg, s_ram, s_stk, s_ee, s_eprom_program_register, s_boot, s_vec;
    wire logic [31:0] ldata;
    wire logic [3:0] lvalid;
    int mismatches = 0, n_checks = 0, cyc = 0;
    always #2 mclk = ~mclk;
    lpmd_core #(.EPROM_PART(1), .STOP_DISABLE(0), .STOP_DELAY(SD)) u_dut (
        .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(rdata), .stop_exec(stop_exec), .wait_exec(wait_exec),
        .irq_ext(irq[0]), .irq_kbd(irq[1]), .irq_low_voltage_input(irq[2]),
        .irq_core_timer(irq[3]), .irq_timer16(irq[4]), .cpu_addr(cpu_addr),
        .cpu_wdata(cpu_wdata), .cpu_wr(cpu_wr), .cpu_rd(1'b0), .bus_clk_en(), .osc_run(osc),
        .cpu_run(run), .core_timer_run(ctr), .timer16_run(t16r), .adc_run(adcr),
        .clear_imask(clr), .sel_reg(s_reg), .sel_ram(s_ram), .sel_stack(s_stk), .sel_ee(s_ee),
        .sel_eprom_program_register(s_eprom_program_register), .sel_boot(s_boot), .sel_vec(s_vec), .eprom_program_register_read_en(),
        .eprom_latch_addr(), .eprom_latch_data(ldata), .eprom_latch_valid(lvalid),
        .eprom_pgm(pgm));
    lpmd_cpu_model u_cpu (.mclk(mclk), .rst(rst), .cpu_run(run), .cmd(cmd),
        .stop_exec(stop_exec), .wait_exec(wait_exec));
    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [35:0] s, input logic [35:0] e);
        n_checks++;
        if (s !== e) begin
            mismatches++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e, input string nm);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(negedge mclk);
        chk(nm, rdata, e);
        @(posedge mclk);
    endtask
    function automatic logic [6:0] es(input logic [12:0] a, input logic lat);
        es = {a <= 13'h001F, a >= 13'h0080 && a <= 13'h00FF, a >= 13'h00C0 && a <= 13'h00FF,
            a >= 13'h0100 && a <= 13'h019F, a >= 13'h0700 && a <= 13'h1EFF,
            a >= 13'h1F00 && a <= 13'h1FDF && !lat, a >= 13'h1FF0};
    endfunction
    task automatic dec(input logic lat);
        logic [12:0] a;
        for (int i = 0; i < 120; i++) begin
            a = i < 8 ? cor[i] : 13'($urandom());
            cpu_addr <= a;
            @(negedge mclk);
            chk("sel", {s_reg, s_ram | s_stk, s_stk, s_ee, s_eprom_program_register, s_boot, s_vec}, es(a, lat));
            @(posedge mclk);
        end
    endtask
    // Waits are bounded so a core that never wakes cannot hang the run.
    task automatic lp(input logic stp, input int src, input logic wake);
        int n;
        cmd <= stp ? 2'h1 : 2'h2;
        @(posedge mclk);
        cmd <= 2'h0;
        ims = 1'b0;
        repeat (3) @(posedge mclk);
        chk("run", {osc, run, ctr, t16r, adcr}, stp ? 5'h00 : 5'h17);
        chk("imask", ims, 1'b1);
        irq <= 5'h01 << src;
        for (n = 0; run !== 1'b1 && n < 60; n++)
            @(posedge mclk);
        chk("wake", run, wake);
        if (wake)
            chk("hold", n < 2 * SD, !stp);
        irq <= 5'h01;
        for (n = 0; run !== 1'b1 && n < 60; n++)
            @(posedge mclk);
        irq <= 5'h00;
        repeat (2) @(posedge mclk);
    endtask
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (clr)
            ims <= 1'b1;
        if (cyc == 20000) begin
            mismatches++;
            complete_run();
        end
    end
    initial begin
        logic [12:0] a;
        logic [31:0] ed;
        void'($urandom(32'hdda8));
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        rd(4'h2, 8'h00, "eprom_program_register_rst");
        wr(4'hF, 8'hFF);
        rd(4'hF, 8'h00, "unmapped");
        rd(4'h0, 8'h00, "ctrl");
        wr(4'h2, 8'h05);
        rd(4'h2, 8'h04, "eprom_program_register_one");
        // Bytes are latched before program power is applied, as in the real sequence.
        a = 13'h0700 + ((13'($urandom()) % 13'h1800) & 13'h1FFC);
        cpu_wr <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            ed[8*(i%4)+:8] = i < 4 ? 8'($urandom()) : ed[7:0];
            cpu_addr <= i < 4 ? a + 13'(i) : a ^ 13'h0010;
            cpu_wdata <= i < 4 ? ed[8*(i%4)+:8] : ~ed[7:0];
            @(posedge mclk);
        end
        cpu_wr <= 1'b0;
        @(posedge mclk);
        chk("latch", {lvalid, ldata}, {4'hF, ed});
        wr(4'h2, 8'h05);
        rd(4'h1, 8'h04, "status");
        chk("pgm", pgm, 1'b1);
        dec(1'b1);
        wr(4'h2, 8'h00);
        @(posedge mclk);
        chk("pgm_off", pgm, 1'b0);
        dec(1'b0);
        wr(4'h0, 8'h0F);
        for (int s = 0; s < 5; s++) begin
            lp(1'b1, s, s < 3);
            lp(1'b0, s, 1'b1);
        end
        wr(4'h0, 8'h00);
        lp(1'b0, 1, 1'b0);
        lp(1'b1, 2, 1'b0);
        cmd <= 2'h1;
        @(posedge mclk);
        cmd <= 2'h0;
        repeat (4) @(posedge mclk);
        rst <= 1'b1;
        @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        chk("rst_wake", {osc, run}, 2'h3);
        complete_run();
    end
endmodule
`default_nettype wire

// ===== bench/lpmd_cpu_model.sv
// Purpose: CPU core stand-in issuing stop and wait.
// Assumes: A halted core executes nothing.
// Notes: A bench command becomes a one-cycle pulse.
`timescale 1ns/1ps
`default_nettype none
module lpmd_cpu_model (
    // Clock, reset, core state
    input wire logic mclk,
    input wire logic rst,
    input wire logic cpu_run,
    // Command and instruction pulses
    input wire logic [1:0] cmd,
    output logic stop_exec = 1'b0,
    output logic wait_exec = 1'b0
);
    // Gated by cpu_run, so nothing is issued in wait or restart.
    always @(posedge mclk) begin
        stop_exec <= !rst && cpu_run && cmd == 2'h1;
        wait_exec <= !rst && cpu_run && cmd == 2'h2;
    end
endmodule
`default_nettype wire

// ===== rtl/lpmd_core.v
// Purpose: Low-power mode control and memory map decode for an 8-bit core.
// Assumes: CPU core signals stop and wait executions as one-cycle pulses.
// Notes: Oscillator gating is modelled as a clock-run output.
// Behaviour
// - Stop turns oscillator off, freezing core timer and watchdog.
// - Entering stop clears interrupt mask; everything else unchanged.
// - Stop exits only on external, enabled keyboard or low-voltage interrupt, or reset.
// - ROM variant option may turn stop into a no-operation.
// - After stop wake, hold off 4064 cycles before resuming.
// - Wait halts CPU; core timer, 16-bit timer and converter keep running.
// - Wait exits on external, or enabled keyboard, low-voltage or timer interrupts.
// - Entering wait clears interrupt mask; all else keeps state.
// - Decoder presents an 8K map of all regions.
// - Registers decode in lowest 32 bytes.
// - User RAM is 128 bytes at 0x0080 to 0x00FF.
// - EPROM variant decodes boot ROM at 0x1F00 to 0x1FDF.
// - Boot ROM blocked while program latch bit set.
// - ROM variant decodes program ROM at 0x0800 to 0x1F6F.
// - Both variants decode vectors at 0x1FF0 to 0x1FFF.
// - EPROM variant decodes program EPROM at 0x0700 to 0x1EFF.
// - EPROM programs up to four bytes per operation.
// - Bus clock runs at half the oscillator.
// - Latch set blocks EPROM reads and latches address and data on writes.
`timescale 1ns/1ps
`default_nettype none
`include "lpmd_regs.vh"
module lpmd_core #(
    parameter EPROM_PART = 1,
    parameter STOP_DISABLE = 0,
    parameter STOP_DELAY = `LPMD_STOP_DELAY
) (
    // Clock and reset
    input wire mclk,
    input wire rst,
    // Register port
    input wire [3:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    // CPU core requests
    input wire stop_exec,
    input wire wait_exec,
    // Interrupt sources
    input wire irq_ext,
    input wire irq_kbd,
    input wire irq_low_voltage_input,
    input wire irq_core_timer,
    input wire irq_timer16,
    // CPU bus for decode
    input wire [12:0] cpu_addr,
    input wire [7:0] cpu_wdata,
    input wire cpu_wr,
    input wire cpu_rd,
    // Clock and power control
    output reg bus_clk_en,
    output reg osc_run,
    output reg cpu_run,
    output reg core_timer_run,
    output reg timer16_run,
    output reg adc_run,
    output reg clear_imask,
    // Region selects
    output wire sel_reg,
    output wire sel_ram,
    output wire sel_stack,
    output wire sel_ee,
    output wire sel_eprom_program_register,
    output wire sel_boot,
    output wire sel_vec,
    output wire eprom_program_register_read_en,
    // EPROM programming
    output reg [12:0] eprom_latch_addr,
    output reg [31:0] eprom_latch_data,
    output reg [3:0] eprom_latch_valid,
    output wire eprom_pgm
);
    localparam ST_RUN = 2'b00;
    localparam ST_STOP = 2'b01;
    localparam ST_WAIT = 2'b10;
    localparam ST_RESTART = 2'b11;

    reg [1:0] state;
    reg [1:0] next_state;
    reg [7:0] ctrl;
    reg [7:0] eprom_program_register;
    reg bus_phase;
    reg delay_start;
    wire delay_busy;
    wire delay_done;
    wire latch_set;
    wire stop_wake;
    wire wait_wake;
    wire eprom_program_register_wr;
    reg [7:0] next_eprom_program_register;

    assign latch_set = eprom_program_register[`LPMD_EPROM_PROGRAM_REGISTER_LATCH_BIT];
    assign eprom_pgm = eprom_program_register[`LPMD_EPROM_PROGRAM_REGISTER_PGM_BIT];

    // Software interrupt enables: bit0 keyboard, bit1 low-voltage, bit2 core timer, bit3 timer.
    // stop wake sources
    assign stop_wake = irq_ext || (irq_kbd && ctrl[0]) ||
        (irq_low_voltage_input && ctrl[1]);
    assign wait_wake = stop_wake || (irq_core_timer && ctrl[2]) ||
        (irq_timer16 && ctrl[3]);

    // The phase is parked at 0 in stop so that the restart count always
    // begins on the same phase; this makes the restart length repeatable
    // to the cycle, at the cost of one idle mclk after wake.
    // bus clock at half rate
    always @(posedge mclk) begin
        if (rst) begin
            bus_phase <= 1'b0;
        end else if (state == ST_STOP) begin
            bus_phase <= 1'b0;
        end else begin
            bus_phase <= ~bus_phase;
        end
    end

    always @* begin
        next_state = state;
        delay_start = 1'b0;
        case (state)
            ST_RUN: begin
                if (stop_exec && !(EPROM_PART == 0 && STOP_DISABLE != 0)) begin
                    next_state = ST_STOP;
                end else if (wait_exec) begin
                    next_state = ST_WAIT;
                end
            end
            ST_STOP: begin
                if (stop_wake) begin
                    next_state = ST_RESTART;
                    delay_start = 1'b1;
                end
            end
            ST_WAIT: begin
                if (wait_wake) begin
                    next_state = ST_RUN;
                end
            end
            ST_RESTART: begin
                if (delay_done) begin
                    next_state = ST_RUN;
                end
            end
            default: begin
                next_state = ST_RUN;
            end
        endcase
    end

    always @(posedge mclk) begin
        if (rst) begin
            state <= ST_RUN;
            clear_imask <= 1'b0;
        end else begin
            state <= next_state;
            clear_imask <= (state == ST_RUN) &&
                (next_state == ST_STOP || next_state == ST_WAIT);
        end
    end

    // Run outputs registered so the gating is glitch free.
    always @(posedge mclk) begin
        if (rst) begin
            osc_run <= 1'b1;
            cpu_run <= 1'b1;
            core_timer_run <= 1'b1;
            timer16_run <= 1'b1;
            adc_run <= 1'b1;
            bus_clk_en <= 1'b0;
        end else begin
            osc_run <= (next_state != ST_STOP);
            core_timer_run <= (next_state == ST_RUN) || (next_state == ST_WAIT);
            cpu_run <= (next_state == ST_RUN);
            timer16_run <= (next_state == ST_RUN) || (next_state == ST_WAIT);
            adc_run <= (next_state == ST_RUN) || (next_state == ST_WAIT);
            bus_clk_en <= ~bus_phase && (next_state != ST_STOP);
        end
    end

    lpmd_delay #(
        .CYCLES(STOP_DELAY)
    ) u_delay (
        .mclk(mclk),
        .rst(rst),
        .start(delay_start),
        .bus_tick(bus_phase),
        .busy(delay_busy),
        .done(delay_done)
    );

    lpmd_decode #(
        .EPROM_PART(EPROM_PART)
    ) u_decode (
        .addr(cpu_addr),
        .latch_set(latch_set),
        .sel_reg(sel_reg),
        .sel_ram(sel_ram),
        .sel_stack(sel_stack),
        .sel_ee(sel_ee),
        .sel_eprom_program_register(sel_eprom_program_register),
        .sel_boot(sel_boot),
        .sel_vec(sel_vec)
    );

    assign eprom_program_register_read_en = sel_eprom_program_register && !latch_set;

    // The programming register is reached from the CPU bus and the register port.
    assign eprom_program_register_wr = (reg_wr && reg_addr == `LPMD_OFF_EPROM_PROGRAM_REGISTER) ||
        (cpu_wr && cpu_addr == `LPMD_EPROM_PROGRAM_REGISTER_ADDR);

    always @* begin
        next_eprom_program_register = eprom_program_register;
        if (eprom_program_register_wr) begin
            next_eprom_program_register = `LPMD_EPROM_PROGRAM_REGISTER_RESET;
            // The latch bit of the written byte is taken as is; bits other than latch and program power read back as 0.
            next_eprom_program_register[`LPMD_EPROM_PROGRAM_REGISTER_LATCH_BIT] = reg_wr ? reg_wdata[`LPMD_EPROM_PROGRAM_REGISTER_LATCH_BIT] :
                cpu_wdata[`LPMD_EPROM_PROGRAM_REGISTER_LATCH_BIT];
            // Program power only if the latch was already set, never together.
            next_eprom_program_register[`LPMD_EPROM_PROGRAM_REGISTER_PGM_BIT] = latch_set &&
                next_eprom_program_register[`LPMD_EPROM_PROGRAM_REGISTER_LATCH_BIT] &&
                (reg_wr ? reg_wdata[`LPMD_EPROM_PROGRAM_REGISTER_PGM_BIT] : cpu_wdata[`LPMD_EPROM_PROGRAM_REGISTER_PGM_BIT]);
        end
    end

    always @(posedge mclk) begin
        if (rst) begin
            ctrl <= `LPMD_CTRL_RESET;
            eprom_program_register <= `LPMD_EPROM_PROGRAM_REGISTER_RESET;
        end else begin
            eprom_program_register <= next_eprom_program_register;
            if (reg_wr && reg_addr == `LPMD_OFF_CTRL) begin
                ctrl <= reg_wdata;
            end
        end
    end

    // Writes are only latched while program power is off, so the bytes that
    // are being programmed cannot change under the array. A write outside
    // the first block is dropped rather than restarting the block; software
    // must clear the latch bit to begin a new block.
    // four-byte latch block
    always @(posedge mclk) begin
        if (rst || !latch_set) begin
            eprom_latch_addr <= 13'h0000;
            eprom_latch_data <= 32'h00000000;
            eprom_latch_valid <= 4'h0;
        end else if (cpu_wr && sel_eprom_program_register && !eprom_pgm) begin
            if (eprom_latch_valid == 4'h0 ||
                    eprom_latch_addr[12:2] == cpu_addr[12:2]) begin
                eprom_latch_addr <= cpu_addr;
                eprom_latch_valid[cpu_addr[1:0]] <= 1'b1;
                eprom_latch_data[{cpu_addr[1:0], 3'b000} +: 8] <= cpu_wdata;
            end
        end
    end

    // Read data is zero outside the answer cycle, so the port can be wire-ORed.
    always @(posedge mclk) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `LPMD_OFF_CTRL: reg_rdata <= ctrl;
                `LPMD_OFF_STATUS: reg_rdata <= {4'h0, delay_busy, latch_set, state};
                `LPMD_OFF_EPROM_PROGRAM_REGISTER: reg_rdata <= eprom_program_register;
                `LPMD_OFF_ELAT_ADDR: reg_rdata <= {eprom_latch_valid, 4'h0};
                `LPMD_OFF_ELAT_DATA: reg_rdata <= eprom_latch_data[7:0];
                default: reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end
endmodule
`default_nettype wire

// ===== rtl/lpmd_decode.v
// Purpose: Combinational decode of the 8K memory map into region selects.
// Assumes: Address is a byte address; variant fixed by parameter.
// Notes: The decode gives one-hot selects except that stack overlaps RAM; unmapped space selects nothing.
`timescale 1ns/1ps
`default_nettype none
`include "lpmd_regs.vh"
module lpmd_decode #(
    parameter EPROM_PART = 1
) (
    // Address and qualifiers
    input wire [12:0] addr,
    input wire latch_set,
    // Region selects
    output wire sel_reg,
    output wire sel_ram,
    output wire sel_stack,
    output wire sel_ee,
    output wire sel_eprom_program_register,
    output wire sel_boot,
    output wire sel_vec
);
    wire in_boot;
    wire in_eprom_program_register;
    assign sel_reg = (addr <= `LPMD_REG_LAST);
    assign sel_ram = (addr >= `LPMD_RAM_LO) && (addr <= `LPMD_RAM_HI);
    assign sel_stack = (addr >= `LPMD_STACK_LO) && (addr <= `LPMD_STACK_HI);
    assign sel_ee = (addr >= `LPMD_EE_LO) && (addr <= `LPMD_EE_HI);
    assign in_boot = (addr >= `LPMD_BOOT_LO) && (addr <= `LPMD_BOOT_HI);
    assign sel_boot = (EPROM_PART != 0) && in_boot && !latch_set;
    assign in_eprom_program_register = (EPROM_PART != 0) ?
        ((addr >= `LPMD_EPROM_LO) && (addr <= `LPMD_EPROM_HI)) :
        ((addr >= `LPMD_ROM_LO) && (addr <= `LPMD_ROM_HI));
    assign sel_eprom_program_register = in_eprom_program_register;
    assign sel_vec = (addr >= `LPMD_VEC_LO);
endmodule
`default_nettype wire

// ===== rtl/lpmd_delay.v
// Purpose: Stop-exit restart counter in bus cycles.
// Assumes: Bus tick marks one bus cycle; reset wins over the count.
// Notes: Done pulses for one mclk when the count completes.
`timescale 1ns/1ps
`default_nettype none
module lpmd_delay #(
    parameter CYCLES = 4064
) (
    // Clock and reset
    input wire mclk,
    input wire rst,
    // Control
    input wire start,
    input wire bus_tick,
    output reg busy,
    output reg done
);
    reg [12:0] count;
    always @(posedge mclk) begin
        if (rst) begin
            count <= 13'h0000;
            busy <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start) begin
                count <= 13'h0000;
                busy <= 1'b1;
            end else if (busy && bus_tick) begin
                if (count == CYCLES[12:0] - 13'h0001) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end
                count <= count + 13'h0001;
            end
        end
    end
endmodule
`default_nettype wire

// ===== rtl/lpmd_regs.vh
// Purpose: Constants for the low-power controller and the memory decoder.
// Assumes: Byte addresses of a 13-bit (8K) map; bus clock at half of mclk.
// Notes: Register offsets are word indices on the plain register port.
`ifndef LPMD_REGS_VH
`define LPMD_REGS_VH
`define LPMD_ADDR_W 13
`define LPMD_REG_LAST 13'h001F
`define LPMD_RAM_LO 13'h0080
`define LPMD_RAM_HI 13'h00FF
`define LPMD_STACK_LO 13'h00C0
`define LPMD_STACK_HI 13'h00FF
`define LPMD_EE_LO 13'h0100
`define LPMD_EE_HI 13'h019F
`define LPMD_EPROM_LO 13'h0700
`define LPMD_EPROM_HI 13'h1EFF
`define LPMD_ROM_LO 13'h0800
`define LPMD_ROM_HI 13'h1F6F
`define LPMD_BOOT_LO 13'h1F00
`define LPMD_BOOT_HI 13'h1FDF
`define LPMD_VEC_LO 13'h1FF0
`define LPMD_VEC_HI 13'h1FFF
`define LPMD_EPROM_PROGRAM_REGISTER_ADDR 13'h001D
`define LPMD_EPROM_PROGRAM_REGISTER_LATCH_BIT 2
`define LPMD_EPROM_PROGRAM_REGISTER_PGM_BIT 0
`define LPMD_EPROM_PROGRAM_REGISTER_RESET 8'h00
`define LPMD_STOP_DELAY 4064
`define LPMD_OFF_CTRL 4'h0
`define LPMD_OFF_STATUS 4'h1
`define LPMD_OFF_EPROM_PROGRAM_REGISTER 4'h2
`define LPMD_OFF_ELAT_ADDR 4'h3
`define LPMD_OFF_ELAT_DATA 4'h4
`define LPMD_CTRL_RESET 8'h00
`endif
